// >>> common/port0_in_pkg.sv
// Shared constants and types for the port 0 receive input path.
// Assumes a single 50 MHz system clock on both ends of the link.
package port0_in_pkg;
	// ==========================================================
	// Port 0 modes
	typedef enum logic [1:0] {
		MODE_MII_MAC,
		MODE_MII_PHY,
		MODE_RMII_PHY
	} port_mode_e;

	// ==========================================================
	// Widths and symbol counts
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int DIBIT_W = 2;
	localparam logic [2:0] MII_CHUNKS = 3'h2;
	localparam logic [2:0] RMII_CHUNKS = 3'h4;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	localparam int SYNC_W = 7;
	localparam int SYNC_CLK = 0;
	localparam int SYNC_VALID = 5;
	localparam int SYNC_ERROR = 6;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int LINK_CLK_PERIOD_NS = 160;
	localparam int LINK_HALF_INT = LINK_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [2:0] LINK_HALF_M1 = 3'(LINK_HALF_INT - 1);
endpackage : port0_in_pkg

// >>> common/port0_in_if.sv
// Port 0 input pins between the switch input path and the far MAC or PHY.
// Assumes the bench joins both ends; the clock pin is resolved here.
`timescale 1ns/10ps
`default_nettype none
interface port0_in_if;
	logic [3:0] data;
	logic valid;
	logic error;
	logic ref_clk_far;
	logic ref_clk_far_oe;
	logic ref_clk_dev;
	logic ref_clk_dev_oe;
	logic ref_clk;

	// ==========================================================
	// Clock pin level: device driver, far driver, else pull-down
	assign ref_clk = ref_clk_dev_oe ? ref_clk_dev : (ref_clk_far_oe ? ref_clk_far : 1'b0);

	modport dev (
		input data,
		input valid,
		input error,
		input ref_clk,
		output ref_clk_dev,
		output ref_clk_dev_oe
	);

	modport far (
		output data,
		output valid,
		output error,
		output ref_clk_far,
		output ref_clk_far_oe,
		input ref_clk
	);
endinterface : port0_in_if
`default_nettype wire

// >>> hdl/port0_far_end.sv
// Far end of the port 0 input link: external PHY (MII MAC mode) or
// external MAC (PHY modes) sending bytes as nibbles or dibits.
// Assumes the mode is static while a frame is in flight.
`timescale 1ns/10ps
`default_nettype none
module port0_far_end (
	input wire logic clk,
	input wire logic rst,
	port0_in_if.far link,
	input wire port0_in_pkg::port_mode_e mode,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_error,
	input wire logic tx_last,
	output logic tx_busy
);
	import port0_in_pkg::*;

	logic [2:0] div_reg;
	logic clk_out_reg;
	logic [1:0] sync_reg;
	logic fall_prev_reg;
	logic hold_valid_reg;
	logic [7:0] hold_data_reg;
	logic hold_err_reg;
	logic hold_last_reg;
	logic [7:0] sh_data_reg;
	logic [2:0] sh_left_reg;
	logic sh_err_reg;
	logic sh_last_reg;
	logic gap_reg;
	logic [3:0] data_reg;
	logic valid_reg;
	logic error_reg;

	// ==========================================================
	// Clock ownership and falling edge events
	wire logic own_clk = (mode != MODE_MII_PHY);
	wire logic is_rmii = (mode == MODE_RMII_PHY);
	wire logic div_wrap = (div_reg == LINK_HALF_M1);
	wire logic own_fall = own_clk & div_wrap & clk_out_reg;
	wire logic ext_fall = ~own_clk & fall_prev_reg & ~sync_reg[1];
	wire logic fall = own_fall | ext_fall;
	wire logic [2:0] chunks = is_rmii ? RMII_CHUNKS : MII_CHUNKS;
	wire logic take = fall & ~gap_reg & (sh_left_reg == 3'h0) & hold_valid_reg;
	wire logic more = fall & ~gap_reg & (sh_left_reg != 3'h0);
	wire logic [7:0] src = take ? hold_data_reg : sh_data_reg;
	wire logic [7:0] src_shift = is_rmii ? {2'h0, src[7:2]} : {4'h0, src[7:4]};
	// RMII leaves the upper data pins and the error pin unused; they carry
	// live noise here on purpose, so only the receiver's masking keeps them out
	wire logic [3:0] chunk = src[3:0];
	wire logic last_chunk = take ? (chunks == 3'h1) : (sh_left_reg == 3'h1);

	assign tx_ready = ~hold_valid_reg;
	assign tx_busy = valid_reg;
	assign link.ref_clk_far = clk_out_reg;
	assign link.ref_clk_far_oe = own_clk;
	assign link.data = data_reg;
	assign link.valid = valid_reg;
	assign link.error = error_reg;

	// Divider for the link clock this end owns
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 3'h0;
			clk_out_reg <= 1'b0;
		end else if (div_wrap) begin
			div_reg <= 3'h0;
			clk_out_reg <= ~clk_out_reg;
		end else begin
			div_reg <= div_reg + 3'h1;
		end
	end

	// Two flops on the device-made clock; only the second is read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_reg <= 2'h0;
			fall_prev_reg <= 1'b0;
		end else begin
			sync_reg <= {sync_reg[0], link.ref_clk};
			fall_prev_reg <= sync_reg[1];
		end
	end

	// One-byte holding stage so the user has a full byte time to refill
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_valid_reg <= 1'b0;
			hold_data_reg <= 8'h00;
			hold_err_reg <= 1'b0;
			hold_last_reg <= 1'b0;
		end else if (tx_valid & tx_ready) begin
			hold_valid_reg <= 1'b1;
			hold_data_reg <= tx_data;
			hold_err_reg <= tx_error;
			hold_last_reg <= tx_last;
		end else if (take) begin
			hold_valid_reg <= 1'b0;
		end
	end

	// Chunk shifter, changed only on falling link clock edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh_data_reg <= 8'h00;
			sh_left_reg <= 3'h0;
			sh_err_reg <= 1'b0;
			sh_last_reg <= 1'b0;
			gap_reg <= 1'b0;
			data_reg <= NIB_ZERO;
			valid_reg <= 1'b0;
			error_reg <= 1'b0;
		end else if (take | more) begin
			sh_data_reg <= src_shift;
			sh_left_reg <= (take ? chunks : sh_left_reg) - 3'h1;
			sh_err_reg <= take ? hold_err_reg : sh_err_reg;
			sh_last_reg <= take ? hold_last_reg : sh_last_reg;
			gap_reg <= last_chunk & (take ? hold_last_reg : sh_last_reg);
			data_reg <= chunk;
			valid_reg <= 1'b1;
			error_reg <= take ? hold_err_reg : sh_err_reg;
		end else if (fall) begin
			gap_reg <= 1'b0;
			data_reg <= NIB_ZERO;
			valid_reg <= 1'b0;
			error_reg <= 1'b0;
		end
	end
endmodule : port0_far_end
`default_nettype wire

// >>> hdl/port0_input_path.sv
// Switch port 0 receive input path: samples nibbles or dibits from the
// far end, packs bytes and hands them out through a two-entry buffer.
// Assumes mode and isolate come from static configuration logic.
`timescale 1ns/10ps
`default_nettype none
module port0_input_path (
	input wire logic clk,
	input wire logic rst,
	port0_in_if.dev link,
	input wire port0_in_pkg::port_mode_e mode,
	input wire logic virtual_phy_isolate,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_error,
	output logic rx_last,
	output logic rx_overflow,
	output logic rx_active
);
	import port0_in_pkg::*;

	typedef enum logic {ST_IDLE, ST_FRAME} rx_state_e;

	rx_state_e state_reg;
	port_mode_e mode_reg;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic clk_prev_reg;
	logic [2:0] div_reg;
	logic clk_out_reg;
	logic [7:0] acc_reg;
	logic [2:0] cnt_reg;
	logic acc_err_reg;
	logic pend_valid_reg;
	logic [7:0] pend_data_reg;
	logic pend_err_reg;
	logic overflow_reg;
	logic [9:0] buf_mem_reg [0:1];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;

	// ==========================================================
	// Mode decode
	wire logic is_rmii = (mode_reg == MODE_RMII_PHY);
	wire logic phy_side = (mode_reg != MODE_MII_MAC);
	wire logic iso = phy_side & virtual_phy_isolate;
	wire logic drive_clk = (mode_reg == MODE_MII_PHY) & ~virtual_phy_isolate;
	wire logic div_wrap = (div_reg == LINK_HALF_M1);

	// Mode is only taken between frames so a frame is never split
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= MODE_MII_MAC;
		end else if (state_reg == ST_IDLE) begin
			mode_reg <= mode;
		end
	end

	// ==========================================================
	// Reference clock out in MII PHY mode, off under isolate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 3'h0;
			clk_out_reg <= 1'b0;
		end else if (div_wrap) begin
			div_reg <= 3'h0;
			clk_out_reg <= ~clk_out_reg;
		end else begin
			div_reg <= div_reg + 3'h1;
		end
	end

	assign link.ref_clk_dev = clk_out_reg;
	assign link.ref_clk_dev_oe = drive_clk;

	// ==========================================================
	// Pin synchronisers; the clock pin is read back through the same
	// path so data and clock see equal delay in every mode
	wire logic [SYNC_W-1:0] pins = {link.error, link.valid, link.data, link.ref_clk};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			clk_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			clk_prev_reg <= sync2_reg[SYNC_CLK];
		end
	end

	// Input buffers modelled as gates: isolated pins read as pulled low
	wire logic in_valid = sync2_reg[SYNC_VALID] & ~iso;
	wire logic [3:0] in_data = iso ? NIB_ZERO : sync2_reg[4:1];
	wire logic in_err = sync2_reg[SYNC_ERROR] & ~iso & ~is_rmii;
	wire logic sample = sync2_reg[SYNC_CLK] & ~clk_prev_reg;

	// ==========================================================
	// Symbol packing, low chunk first
	wire logic [7:0] acc_mii = {in_data, acc_reg[7:4]};
	wire logic [7:0] acc_rmii = {in_data[1:0], acc_reg[7:2]};
	wire logic [7:0] acc_next = is_rmii ? acc_rmii : acc_mii;
	wire logic [2:0] chunks = is_rmii ? RMII_CHUNKS : MII_CHUNKS;
	wire logic take = sample & in_valid;
	wire logic byte_done = take & (cnt_reg == chunks - 3'h1);
	wire logic frame_end = sample & ~in_valid & (state_reg == ST_FRAME);
	wire logic push_req = (byte_done | frame_end) & pend_valid_reg;
	wire logic push_ready = (count_reg != BUF_DEPTH);
	wire logic push = push_req & push_ready;
	wire logic [9:0] push_word = {frame_end, pend_err_reg, pend_data_reg};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take) begin
						state_reg <= ST_FRAME;
					end
				end
				ST_FRAME: begin
					if (frame_end) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Accumulator; a partial byte at frame end is dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_reg <= 8'h00;
			cnt_reg <= 3'h0;
			acc_err_reg <= 1'b0;
		end else if (byte_done | frame_end) begin
			acc_reg <= acc_next;
			cnt_reg <= 3'h0;
			acc_err_reg <= 1'b0;
		end else if (take) begin
			acc_reg <= acc_next;
			cnt_reg <= cnt_reg + 3'h1;
			acc_err_reg <= acc_err_reg | in_err;
		end
	end

	// One byte held back so the final byte can carry the end mark
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_valid_reg <= 1'b0;
			pend_data_reg <= 8'h00;
			pend_err_reg <= 1'b0;
		end else if (byte_done) begin
			pend_valid_reg <= 1'b1;
			pend_data_reg <= acc_next;
			pend_err_reg <= acc_err_reg | in_err;
		end else if (frame_end) begin
			pend_valid_reg <= 1'b0;
		end
	end

	// Link cannot be stalled, so a full buffer costs a byte; flagged here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_reg <= 1'b0;
		end else begin
			overflow_reg <= push_req & ~push_ready;
		end
	end

	// ==========================================================
	// Two-entry output buffer
	wire logic pop = rx_valid & rx_ready;
	wire logic [9:0] head = buf_mem_reg[rd_ptr_reg];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_mem_reg[0] <= 10'h000;
			buf_mem_reg[1] <= 10'h000;
		end else if (push) begin
			buf_mem_reg[wr_ptr_reg] <= push_word;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg ^ push;
			rd_ptr_reg <= rd_ptr_reg ^ pop;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// Outputs
	assign rx_valid = (count_reg != 2'h0);
	assign rx_data = head[7:0];
	assign rx_error = head[8];
	assign rx_last = head[9];
	assign rx_overflow = overflow_reg;
	assign rx_active = (state_reg == ST_FRAME);
endmodule : port0_input_path
`default_nettype wire

// >>> tb/port0_input_path_asserts.sv
// Concurrent checks on the port 0 link between the far end and the input path.
// Assumes mode and isolate only change while rst is high.
`timescale 1ns/10ps
`default_nettype none
module port0_input_path_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire port0_in_pkg::port_mode_e mode,
	input wire logic virtual_phy_isolate,
	input wire logic [3:0] data,
	input wire logic valid,
	input wire logic error,
	input wire logic ref_clk_far,
	input wire logic ref_clk_far_oe,
	input wire logic ref_clk_dev,
	input wire logic ref_clk_dev_oe,
	input wire logic ref_clk
);
	import port0_in_pkg::*;

	// ==========================================================
	// One clock domain, so clocking and disable are shared
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Mode settles a cycle after reset, hence the short run-in
	a_dev_clk_on: assert property ((mode == MODE_MII_PHY && !virtual_phy_isolate)[*3] |-> ref_clk_dev_oe)
		else $error("device clock driver off in MII PHY mode");
	a_iso_clk_off: assert property (virtual_phy_isolate |-> !ref_clk_dev_oe)
		else $error("device clock driven while isolated");
	a_far_clk_oe: assert property (ref_clk_far_oe == (mode != MODE_MII_PHY))
		else $error("far clock driver wrong for mode");
	a_one_driver: assert property (!(ref_clk_dev_oe && ref_clk_far_oe))
		else $error("both ends drive the clock pin");
	// Symbols must stand a whole link period for the sampler
	a_link_stands: assert property ($changed({data, valid, error}) |=> $stable({data, valid, error})[*7])
		else $error("link symbol held under one period");
	a_clk_high: assert property ($rose(ref_clk) |=> ref_clk[*3] ##1 !ref_clk)
		else $error("reference clock high time wrong");
	a_clk_low: assert property ($fell(ref_clk) |=> !ref_clk[*3])
		else $error("reference clock low time too short");
	// Each end's divider must keep its half period even while not driving
	a_dev_clk_half: assert property ($changed(ref_clk_dev) |=> $stable(ref_clk_dev)[*3])
		else $error("device clock half period too short");
	a_far_clk_half: assert property ($changed(ref_clk_far) |=> $stable(ref_clk_far)[*3])
		else $error("far clock half period too short");
	a_change_low: assert property (ref_clk_far_oe && $changed(data) |-> !ref_clk)
		else $error("data changed while clock high");
endmodule : port0_input_path_asserts
`default_nettype wire

// >>> tb/port0_input_path_bench.sv
// Bench: far end feeds the input path over the shared link interface.
// Assumes package, interface and both design ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
module port0_input_path_bench;
	import port0_in_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	port_mode_e mode = MODE_MII_MAC;
	logic virtual_phy_isolate = 1'b0;
	logic tx_valid = 1'b0, tx_error = 1'b0, tx_last = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic rx_ready = 1'b0, hold = 1'b0, seen_act = 1'b0;
	logic tx_ready, tx_busy, rx_valid, rx_error, rx_last, rx_overflow, rx_active;
	logic [7:0] rx_data;
	logic [9:0] exp_q[$];
	int error_cnt = 0, n_compared = 0, n_ovf = 0, cyc = 0;

	// ==========================================================
	// Both ends joined by one link
	port0_in_if link_if();
	port0_far_end port0_far_end_i(.clk(clk), .rst(rst), .link(link_if.far), .mode(mode),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_error(tx_error),
		.tx_last(tx_last), .tx_busy(tx_busy));
	port0_input_path port0_input_path_i(.clk(clk), .rst(rst), .link(link_if.dev), .mode(mode),
		.virtual_phy_isolate(virtual_phy_isolate), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .rx_error(rx_error), .rx_last(rx_last),
		.rx_overflow(rx_overflow), .rx_active(rx_active));
	port0_input_path_asserts port0_input_path_asserts_i(.clk(clk), .rst(rst), .mode(mode),
		.virtual_phy_isolate(virtual_phy_isolate), .data(link_if.data), .valid(link_if.valid),
		.error(link_if.error), .ref_clk_far(link_if.ref_clk_far),
		.ref_clk_far_oe(link_if.ref_clk_far_oe), .ref_clk_dev(link_if.ref_clk_dev),
		.ref_clk_dev_oe(link_if.ref_clk_dev_oe), .ref_clk(link_if.ref_clk));

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	// Random receiver stalls; hold forces a long stall to fill the buffer
	always @(negedge clk) rx_ready <= hold ? 1'b0 : 1'($urandom);

	// ==========================================================
	// Checking helpers
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task automatic final_report();
		$display("compared %0d, wrong %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// Pops are compared against the oldest note; an unnoted pop meets x
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rx_overflow === 1'b1) n_ovf <= n_ovf + 1;
		if (rx_active === 1'b1) seen_act <= 1'b1;
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			check({rx_error, rx_last, rx_data}, exp_q.size() > 0 ? exp_q.pop_front() : 10'hXXX);
		if (cyc == 6000) begin
			error_cnt++;
			final_report();
		end
	end

	// ==========================================================
	// Stimulus; only the first keep bytes are expected to arrive
	task automatic send_frame(input int n, input int keep);
		logic [7:0] d;
		logic e;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			e = ($urandom_range(0, 3) == 0);
			tx_data <= d;
			tx_error <= e;
			tx_last <= (i == n - 1);
			tx_valid <= 1'b1;
			while (tx_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
			if (i < keep) exp_q.push_back({e && mode != MODE_RMII_PHY, i == n - 1, d});
			@(negedge clk);
		end
		tx_valid <= 1'b0;
	endtask : send_frame

	// Mode and isolate only change under reset, as a static setting
	task automatic run(input port_mode_e m, input logic iso, input int n, input int keep);
		logic stall;
		stall = keep > 0 && keep < n;
		rst <= 1'b1;
		mode <= m;
		virtual_phy_isolate <= iso;
		hold <= stall;
		repeat (10) @(negedge clk);
		n_ovf = 0;
		seen_act = 1'b0;
		rst <= 1'b0;
		@(negedge clk);
		send_frame(n, keep);
		repeat (8) @(negedge clk);
		while (tx_busy === 1'b1) @(negedge clk);
		repeat (16) @(negedge clk);
		check(10'(n_ovf), 10'(stall ? n - keep : 0));
		check(10'(seen_act), 10'(keep > 0));
		hold <= 1'b0;
		while (exp_q.size() > 0) @(negedge clk);
		repeat (4) @(negedge clk);
		$display("test done: mode %0d isolate %0b bytes %0d", m, iso, n);
	endtask : run

	initial begin
		void'($urandom(32));
		run(MODE_MII_MAC, 1'b1, 6, 6);
		run(MODE_MII_PHY, 1'b0, 6, 6);
		run(MODE_RMII_PHY, 1'b0, 6, 6);
		run(MODE_RMII_PHY, 1'b1, 3, 0);
		run(MODE_MII_MAC, 1'b0, 4, 2);
		final_report();
	end
endmodule : port0_input_path_bench
`default_nettype wire
